// >>> design/kgp_pin_cell.sv
// One GPIO pin cell: synchroniser, output enable and read-back mux.
// Assumes the pad level arrives asynchronously.
`default_nettype none
module kgp_pin_cell (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control from registers
	input wire logic latch_i,
	input wire logic dir_i,
	input wire logic wake_en_i,
	// Pad
	input wire logic pad_i,
	output logic pad_o,
	output logic pad_oe_o,
	// Read-back and synchronised pin level
	output logic rd_o,
	output logic pin_sync_o
);
	logic meta_r;
	logic sync_r;
	// Two-stage synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= pad_i;
			sync_r <= meta_r;
		end
	end
	// Drive only when output and not taken by wake module
	assign pad_oe_o = dir_i & ~wake_en_i;
	assign pad_o = latch_i;
	// Latch when output, pin level when input
	assign rd_o = dir_i ? latch_i : sync_r;
	assign pin_sync_o = sync_r;
endmodule
`default_nettype wire

// >>> design/kgp_pkg.sv
// Package for the keypad-shared GPIO ports: offsets, widths, reset values.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
`default_nettype none
package kgp_pkg;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] KGP_IDX_THREE_DATA = 8'h0A;
	localparam logic [7:0] KGP_IDX_TWO_DATA = 8'h0B;
	localparam logic [7:0] KGP_IDX_THREE_DIR = 8'h0E;
	localparam logic [7:0] KGP_IDX_TWO_DIR = 8'h0F;
	localparam logic [7:0] KGP_IDX_WAKE_CTRL = 8'h10;
	// Port widths
	localparam int KGP_THREE_W = 3;
	localparam int KGP_TWO_W = 2;
	// Wake-enable field positions in the control register
	localparam int KGP_WAKE_THREE_LSB = 0;
	localparam int KGP_WAKE_TWO_LSB = 3;
	localparam int KGP_WAKE_W = 5;
	// Reset values
	localparam logic [2:0] KGP_THREE_DIR_RST = 3'h0;
	localparam logic [1:0] KGP_TWO_DIR_RST = 2'h0;
	localparam logic [4:0] KGP_WAKE_RST = 5'h00;
	// Slave states
	typedef enum logic [1:0] {
		KGP_IDLE = 2'b01,
		KGP_ACK = 2'b10
	} kgp_state_t;
endpackage
`default_nettype wire

// >>> design/kgp_ports.sv
// Top of the keypad-shared GPIO ports: Wishbone registers and five pin cells.
// Assumes classic Wishbone single cycles and asynchronous pad inputs.
//
// Functional notes
// - First port has three pins, latch, direction.
// - Second port has two wake-shared pins.
// - First-port direction one drives, zero tristates.
// - Second-port direction one drives, zero inputs.
// - Reset clears first-port direction bits.
// - Reset clears second-port direction bits.
// - First data read: latch if output, else pin.
// - Second data read: latch if output, else pin.
// - Data writes with byte lane 0 selected always update the latch.
// - Input pin: write changes only latch.
// - Reset leaves second-port latch unchanged.
// - Reset leaves first-port latch unchanged.
// - Wake enable overrides first-port direction.
// - Wake enables four, three take second port.
`default_nettype none
module kgp_ports
	import kgp_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// First port pads
	input wire logic [2:0] three_pad_i,
	output logic [2:0] three_pad_o,
	output logic [2:0] three_pad_oe_o,
	// Second port pads
	input wire logic [1:0] two_pad_i,
	output logic [1:0] two_pad_o,
	output logic [1:0] two_pad_oe_o,
	// Wake pins to keypad module
	output logic [4:0] keypad_wake_pin_o,
	output logic [4:0] keypad_wake_enable_o
);
	kgp_state_t state_r;
	logic [2:0] port_three_data_latch_r;
	logic [1:0] port_two_data_latch_r;
	logic [2:0] port_three_direction_r;
	logic [1:0] port_two_direction_r;
	logic [4:0] keypad_wake_control_r;
	logic [4:0] pin_rd;
	logic [4:0] pin_sync;
	logic [4:0] all_latch;
	logic [4:0] all_dir;
	logic [4:0] all_oe;
	logic [4:0] all_out;
	logic [4:0] all_pad;
	logic [31:0] rd_nxt;
	logic req;
	logic hit;
	logic wr_lane0;
	logic [5:0] adr_idx;

	// Word index decode
	function automatic logic is_mapped(input logic [7:0] adr);
		logic [5:0] idx;
		idx = adr[7:2];
		is_mapped = ({2'b00, idx} == KGP_IDX_THREE_DATA) || ({2'b00, idx} == KGP_IDX_TWO_DATA)
			|| ({2'b00, idx} == KGP_IDX_THREE_DIR) || ({2'b00, idx} == KGP_IDX_TWO_DIR)
			|| ({2'b00, idx} == KGP_IDX_WAKE_CTRL);
	endfunction

	assign req = wb_cyc_i & wb_stb_i & (state_r == KGP_IDLE);
	assign hit = is_mapped(wb_adr_i);
	assign wr_lane0 = req & hit & wb_we_i & wb_sel_i[0];
	assign adr_idx = wb_adr_i[7:2]; // Word index, used by the checks

	// Answer state: one ack or err per request, dropped next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= KGP_IDLE;
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end else begin
			case (state_r)
				KGP_IDLE: begin
					wb_ack_o <= req & hit;
					wb_err_o <= req & ~hit;
					if (req) begin
						state_r <= KGP_ACK;
					end
				end
				KGP_ACK: begin
					wb_ack_o <= 1'b0;
					wb_err_o <= 1'b0;
					state_r <= KGP_IDLE;
				end
				default: begin
					wb_ack_o <= 1'b0;
					wb_err_o <= 1'b0;
					state_r <= KGP_IDLE;
				end
			endcase
		end
	end

	// Data latches: no reset, written regardless of direction
	always_ff @(posedge clk_i) begin
		if (wr_lane0 && {2'b00, wb_adr_i[7:2]} == KGP_IDX_THREE_DATA) begin
			port_three_data_latch_r <= wb_dat_i[2:0];
		end
		if (wr_lane0 && {2'b00, wb_adr_i[7:2]} == KGP_IDX_TWO_DATA) begin
			port_two_data_latch_r <= wb_dat_i[1:0];
		end
	end

	// Direction registers, cleared by reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_three_direction_r <= KGP_THREE_DIR_RST;
			port_two_direction_r <= KGP_TWO_DIR_RST;
		end else begin
			if (wr_lane0 && {2'b00, wb_adr_i[7:2]} == KGP_IDX_THREE_DIR) begin
				port_three_direction_r <= wb_dat_i[2:0];
			end
			if (wr_lane0 && {2'b00, wb_adr_i[7:2]} == KGP_IDX_TWO_DIR) begin
				port_two_direction_r <= wb_dat_i[1:0];
			end
		end
	end

	// Wake-enable control, cleared by reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			keypad_wake_control_r <= KGP_WAKE_RST;
		end else if (wr_lane0 && {2'b00, wb_adr_i[7:2]} == KGP_IDX_WAKE_CTRL) begin
			keypad_wake_control_r <= wb_dat_i[4:0];
		end
	end

	// Gather five pins into one vector
	assign all_latch = {port_two_data_latch_r, port_three_data_latch_r};
	assign all_dir = {port_two_direction_r, port_three_direction_r};
	assign all_pad = {two_pad_i, three_pad_i};

	// One cell per pin
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_pin
			kgp_pin_cell u_cell (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.latch_i(all_latch[g]),
				.dir_i(all_dir[g]),
				.wake_en_i(keypad_wake_control_r[g]),
				.pad_i(all_pad[g]),
				.pad_o(all_out[g]),
				.pad_oe_o(all_oe[g]),
				.rd_o(pin_rd[g]),
				.pin_sync_o(pin_sync[g])
			);
		end
	endgenerate

	assign three_pad_o = all_out[2:0];
	assign three_pad_oe_o = all_oe[2:0];
	assign two_pad_o = all_out[4:3];
	assign two_pad_oe_o = all_oe[4:3];
	assign keypad_wake_pin_o = pin_sync;
	assign keypad_wake_enable_o = keypad_wake_control_r;

	// Read mux, upper bits zero
	always_comb begin
		rd_nxt = 32'h00000000;
		case ({2'b00, wb_adr_i[7:2]})
			KGP_IDX_THREE_DATA: rd_nxt[2:0] = pin_rd[2:0];
			KGP_IDX_TWO_DATA: rd_nxt[1:0] = pin_rd[4:3];
			KGP_IDX_THREE_DIR: rd_nxt[2:0] = port_three_direction_r;
			KGP_IDX_TWO_DIR: rd_nxt[1:0] = port_two_direction_r;
			KGP_IDX_WAKE_CTRL: rd_nxt[4:0] = keypad_wake_control_r;
			default: rd_nxt = 32'h00000000;
		endcase
	end

	// Read data registered with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (req) begin
			wb_dat_o <= rd_nxt;
		end
	end

	// Checks
	AST_DIR_RESET: assert property (@(posedge clk_i) rst_i |=>
		(port_three_direction_r == 3'h0) && (three_pad_oe_o == 3'h0))
		else $error("first port not input after reset");
	AST_DIR_RESET_TWO: assert property (@(posedge clk_i) rst_i |=>
		(port_two_direction_r == 2'h0) && (two_pad_oe_o == 2'h0))
		else $error("second port not input after reset");
	AST_OE_THREE: assert property (@(posedge clk_i) disable iff (rst_i)
		three_pad_oe_o == (port_three_direction_r & ~keypad_wake_control_r[2:0]))
		else $error("first port enable wrong");
	AST_OE_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
		two_pad_oe_o == (port_two_direction_r & ~keypad_wake_control_r[4:3]))
		else $error("second port enable wrong");
	AST_WAKE_OVR: assert property (@(posedge clk_i) disable iff (rst_i)
		keypad_wake_control_r[0] |-> !three_pad_oe_o[0])
		else $error("wake enable did not override");
	AST_WAKE_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
		keypad_wake_control_r[4] |-> !two_pad_oe_o[1])
		else $error("wake enable four did not override");
	AST_LATCH_WR: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_lane0 && {2'b00, adr_idx} == KGP_IDX_THREE_DATA)
		|=> (port_three_data_latch_r == $past(wb_dat_i[2:0])))
		else $error("latch not written");
	AST_RD_THREE: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && {2'b00, adr_idx} == KGP_IDX_THREE_DATA && !wb_we_i
		&& port_three_direction_r == 3'h7
		&& $stable(port_three_data_latch_r))
		|=> wb_ack_o && wb_dat_o[2:0] == port_three_data_latch_r)
		else $error("read of output latch wrong");
	AST_RD_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> wb_dat_o[31:5] == 27'h0)
		else $error("upper bits not zero");
	AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

	// Bus answer timing and exclusivity
	// Mapped request answered by ack next cycle
	AST_ACK_LAT: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && hit) |=> (wb_ack_o && !wb_err_o))
		else $error("mapped request not acked");
	// Unmapped request answered by err next cycle
	AST_ERR_LAT: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !hit) |=> (wb_err_o && !wb_ack_o))
		else $error("unmapped request not refused");
	// Error pulse lasts one cycle
	AST_ERR_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_err_o |=> !wb_err_o)
		else $error("err held two cycles");
	// Never both answers at once
	AST_ACK_ERR_EXCL: assert property (@(posedge clk_i) disable iff (rst_i)
		!(wb_ack_o && wb_err_o))
		else $error("ack and err together");
	// Ack only while in the answer state
	AST_ACK_STATE: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> (state_r == KGP_ACK))
		else $error("ack outside answer state");
	// No new request taken during the answer cycle
	AST_REQ_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_r == KGP_ACK) |-> !req)
		else $error("request taken while answering");
	// Reset quiets the bus and the wake enables
	AST_RESET_BUS: assert property (@(posedge clk_i) rst_i |=>
		(!wb_ack_o && !wb_err_o && keypad_wake_enable_o == KGP_WAKE_RST
		&& wb_dat_o == 32'h00000000))
		else $error("bus or wake state not cleared by reset");

	// Register writes
	// Unmapped write changes no control register
	AST_ERR_NO_WR: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !hit && wb_we_i) |=> ($stable(port_three_direction_r)
		&& $stable(port_two_direction_r) && $stable(keypad_wake_control_r)))
		else $error("unmapped write changed a register");
	// Second-port latch takes the written bits
	AST_LATCH_WR_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_lane0 && {2'b00, adr_idx} == KGP_IDX_TWO_DATA)
		|=> (port_two_data_latch_r == $past(wb_dat_i[1:0])))
		else $error("second latch not written");
	// First-port direction takes the written bits
	AST_DIR_WR_THREE: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_lane0 && {2'b00, adr_idx} == KGP_IDX_THREE_DIR)
		|=> (port_three_direction_r == $past(wb_dat_i[2:0])))
		else $error("first direction not written");
	// Second-port direction takes the written bits
	AST_DIR_WR_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_lane0 && {2'b00, adr_idx} == KGP_IDX_TWO_DIR)
		|=> (port_two_direction_r == $past(wb_dat_i[1:0])))
		else $error("second direction not written");
	// First-port direction holds without a write to it
	AST_DIR_HOLD_THREE: assert property (@(posedge clk_i) disable iff (rst_i)
		!(wr_lane0 && {2'b00, adr_idx} == KGP_IDX_THREE_DIR)
		|=> $stable(port_three_direction_r))
		else $error("first direction changed unasked");
	// Second-port direction holds without a write to it
	AST_DIR_HOLD_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
		!(wr_lane0 && {2'b00, adr_idx} == KGP_IDX_TWO_DIR)
		|=> $stable(port_two_direction_r))
		else $error("second direction changed unasked");
	// Wake enables hold without a write to them
	AST_WAKE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		!(wr_lane0 && {2'b00, adr_idx} == KGP_IDX_WAKE_CTRL)
		|=> $stable(keypad_wake_control_r))
		else $error("wake enables changed unasked");

	// Read-back
	// First-port input bits read the synchronised pin
	AST_RD_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && {2'b00, adr_idx} == KGP_IDX_THREE_DATA
		&& port_three_direction_r == 3'h0)
		|=> (wb_dat_o[2:0] == $past(keypad_wake_pin_o[2:0])))
		else $error("first port pin read wrong");
	// Second-port input bits read the synchronised pin
	AST_RD_PIN_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && {2'b00, adr_idx} == KGP_IDX_TWO_DATA
		&& port_two_direction_r == 2'h0)
		|=> (wb_dat_o[1:0] == $past(keypad_wake_pin_o[4:3])))
		else $error("second port pin read wrong");
	// Second-port output bit reads its latch
	AST_RD_TWO_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && {2'b00, adr_idx} == KGP_IDX_TWO_DATA
		&& port_two_direction_r[1] && $stable(port_two_data_latch_r))
		|=> (wb_dat_o[1] == port_two_data_latch_r[1]))
		else $error("second port latch read wrong");
	// First-port direction reads back, upper bits zero
	AST_RD_DIR_THREE: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && {2'b00, adr_idx} == KGP_IDX_THREE_DIR)
		|=> (wb_dat_o == {29'h00000000, $past(port_three_direction_r)}))
		else $error("first direction read wrong");
	// Second-port direction reads back, upper bits zero
	AST_RD_DIR_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && {2'b00, adr_idx} == KGP_IDX_TWO_DIR)
		|=> (wb_dat_o == {30'h00000000, $past(port_two_direction_r)}))
		else $error("second direction read wrong");
	// Wake enables read back, upper bits zero
	AST_RD_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && {2'b00, adr_idx} == KGP_IDX_WAKE_CTRL)
		|=> (wb_dat_o == {27'h0000000, $past(keypad_wake_control_r)}))
		else $error("wake enables read wrong");
	// Refused access returns all zero
	AST_RD_ERR_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !hit) |=> (wb_dat_o == 32'h00000000))
		else $error("refused read not zero");

	// Pins and wake sharing
	// Wake-pin levels are the pads two cycles back
	AST_WAKE_PIN_SYNC: assert property (@(posedge clk_i) disable iff (rst_i)
		(!$past(rst_i) && !$past(rst_i, 2))
		|-> (keypad_wake_pin_o == $past({two_pad_i, three_pad_i}, 2)))
		else $error("wake pin levels not synchronised");
	// Wake enable one releases first-port pin one
	AST_WAKE_OVR_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		keypad_wake_control_r[1] |-> !three_pad_oe_o[1])
		else $error("wake enable one did not override");
	// Wake enable two releases first-port pin two
	AST_WAKE_OVR_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
		keypad_wake_control_r[2] |-> !three_pad_oe_o[2])
		else $error("wake enable two did not override");
	// Wake enable three releases second-port pin zero
	AST_WAKE_THREE: assert property (@(posedge clk_i) disable iff (rst_i)
		keypad_wake_control_r[3] |-> !two_pad_oe_o[0])
		else $error("wake enable three did not override");
	// A driven first-port pin shows its latch
	AST_PAD_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i)
		three_pad_oe_o[0] |-> (three_pad_o[0] == port_three_data_latch_r[0]))
		else $error("driven pin not showing latch");
	// A driven second-port pin shows its latch
	AST_PAD_DRIVE_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
		two_pad_oe_o[1] |-> (two_pad_o[1] == port_two_data_latch_r[1]))
		else $error("driven second pin not showing latch");
endmodule
`default_nettype wire

// >>> testbench/kgp_pins_model.sv
// Board-side pin model: settles each pad from device drive and outside drivers.
// Assumes the bench gives the outside driver levels; no pulls on the pads.
`default_nettype none
module kgp_pins_model (
	// Device drive
	input wire logic [4:0] pad_o_i,
	input wire logic [4:0] pad_oe_i,
	// Outside drivers
	input wire logic [4:0] ext_i,
	// Levels at the pads
	output logic [4:0] level_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Device wins where its buffer is on, else the outside driver
	assign level_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & ext_i);
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Bench for the keypad-shared ports: Wishbone tasks and directed tests.
// Assumes the pin model supplies pad levels; one 40 MHz clock.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import kgp_pkg::*;
	localparam logic [7:0] A3D = {KGP_IDX_THREE_DATA[5:0], 2'b00};
	localparam logic [7:0] A2D = {KGP_IDX_TWO_DATA[5:0], 2'b00};
	localparam logic [7:0] A3R = {KGP_IDX_THREE_DIR[5:0], 2'b00};
	localparam logic [7:0] A2R = {KGP_IDX_TWO_DIR[5:0], 2'b00};
	localparam logic [7:0] AW = {KGP_IDX_WAKE_CTRL[5:0], 2'b00};
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, err, e;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [2:0] p3_i, p3_o, p3_oe;
	logic [1:0] p2_i, p2_o, p2_oe;
	logic [4:0] wk_pin, wk_en, lvl, ext = 5'h0A;
	int bad_count = 0, cmp_count = 0;
	// Clock
	always #12.5 clk_i = ~clk_i;
	kgp_ports kgp_ports_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .wb_err_o(err), .three_pad_i(p3_i), .three_pad_o(p3_o),
		.three_pad_oe_o(p3_oe), .two_pad_i(p2_i), .two_pad_o(p2_o), .two_pad_oe_o(p2_oe),
		.keypad_wake_pin_o(wk_pin), .keypad_wake_enable_o(wk_en));
	kgp_pins_model kgp_pins_model_i (.pad_o_i({p2_o, p3_o}), .pad_oe_i({p2_oe, p3_oe}),
		.ext_i(ext), .level_o(lvl));
	// Pad levels back into the ports
	assign p3_i = lvl[2:0];
	assign p2_i = lvl[4:3];
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		cmp_count++;
		if (got !== ex) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// One classic cycle, held until ack or err
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
		q = rdat;
		e = err;
		if (n >= 20) chk("bus answer", 32'h1, 32'h0);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ex);
		wb(1'b0, a, 32'h0);
		chk("read data", ex, q);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#100000;
		bad_count++;
		report_and_stop();
	end
	// Test sequence
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(A3R, 32'h0);
		rd(A2R, 32'h0);
		chk("pad enables", 32'h0, {p2_oe, p3_oe});
		$display("test reset done");
		wb(1'b1, A3D, 32'hFFFF_FFFD);
		wb(1'b1, A2D, 32'h2);
		repeat (4) @(posedge clk_i);
		rd(A3D, 32'h2);
		rd(A2D, 32'h1);
		chk("pad out", 32'h15, {p2_o, p3_o});
		$display("test inputs done");
		wb(1'b1, A3R, 32'hFF);
		wb(1'b1, A2R, 32'h2);
		rd(A3R, 32'h7);
		rd(A3D, 32'h5);
		rd(A2D, 32'h3);
		chk("pad enables", 32'h17, {p2_oe, p3_oe});
		wb(1'b1, A3D, 32'h3);
		rd(A3D, 32'h3);
		$display("test outputs done");
		wb(1'b1, AW, 32'h1F);
		repeat (3) @(posedge clk_i);
		chk("pad enables", 32'h0, {p2_oe, p3_oe});
		chk("wake enables", 32'h1F, wk_en);
		chk("wake pins", 32'h0A, wk_pin);
		wb(1'b1, AW, 32'h0);
		chk("pad enables", 32'h17, {p2_oe, p3_oe});
		wb(1'b1, 8'h04, 32'h0);
		chk("bus error", 32'h1, e);
		$display("test wake done");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("pad out", 32'h13, {p2_o, p3_o});
		rd(A3R, 32'h0);
		rd(A2R, 32'h0);
		$display("test second reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
